// ---- design/reg_field_bank.sv ----
// reg_field_bank: bank of register fields, one per access behaviour
`timescale 1ns/1ps
module reg_field_bank (
    input  wire logic            clk,
    input  wire logic            arst_n,
    input  wire logic            soft_rst,
    input  wire field_pkg::acc_s acc,
    input  wire field_pkg::hw_s  hw,
    output field_pkg::rsp_s      rsp,
    output field_pkg::ctrl_s     ctrl
);
    import field_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic sel(
        input logic [ADDR_W-1:0] addr,
        input int                idx
    );
        int tmp;
        tmp = idx;
        sel = (addr == tmp[ADDR_W-1:0]);
    endfunction : sel

    function automatic logic [DATA_W-1:0] read_view(
        input field_kind_e       kind,
        input logic [DATA_W-1:0] q
    );
        logic [DATA_W-1:0] v;
        v = q;
        if (kind == KIND_WRITE_ONLY) begin
            v = ALL_ZEROS; // write-only data is not returned
        end
        read_view = v;
    endfunction : read_view

    function automatic logic [DATA_W-1:0] field_next(
        input field_kind_e       kind,
        input logic [DATA_W-1:0] q,
        input logic [DATA_W-1:0] hw_in,
        input logic              we,
        input logic [DATA_W-1:0] wd,
        input logic              rfx,
        input logic [DATA_W-1:0] rret,
        input logic [DATA_W-1:0] seen
    );
        logic [DATA_W-1:0] wmask;
        logic [DATA_W-1:0] rmask_hi;
        logic [DATA_W-1:0] rmask_lo;
        logic [DATA_W-1:0] n;
        wmask    = we  ? wd    : ALL_ZEROS;
        rmask_hi = rfx ? rret  : ALL_ZEROS;
        rmask_lo = rfx ? ~rret : ALL_ZEROS;
        n        = q;
        unique case (kind)
            KIND_READ_ONLY: begin
                n = hw_in; // writes never reach this field
            end
            KIND_SET_ON_READ: begin
                n = (q & ~hw_in) | (rfx ? ALL_ONES : ALL_ZEROS);
            end
            KIND_WRITE_ONLY: begin
                n = we ? wd : q;
            end
            KIND_WRITE_ONE_SET: begin
                n = q | wmask;
            end
            KIND_WRITE_ONE_CLEAR: begin
                n = (q & ~wmask) | hw_in; // event wins over clear
            end
            KIND_WRITE_ANY_CLEAR: begin
                n = (q & ~(we ? ALL_ONES : ALL_ZEROS)) | hw_in;
            end
            KIND_LATCH_LOW: begin
                n = (q | rmask_lo) & hw_in; // release only bits returned low
            end
            KIND_LATCH_HIGH: begin
                n = (q & ~rmask_hi) | hw_in; // clear only bits returned high
            end
            KIND_SELF_CLEARING: begin
                n = wmask; // one-cycle pulse, zero bits start nothing
            end
            KIND_STICKY_HIGH: begin
                n = hw_in | (q & ~(seen & ~hw_in));
            end
            KIND_READ_WRITE: begin
                n = we ? wd : q;
            end
            KIND_KEPT_SOFT_RESET: begin
                n = we ? wd : q;
            end
        endcase
        field_next = n;
    endfunction : field_next

    // ------------------------------------------------------------
    // hardware inputs per field
    // ------------------------------------------------------------
    logic [DATA_W-1:0] hw_vec [NUM_REGS];

    assign hw_vec[A_READ_ONLY]       = hw.status;
    assign hw_vec[A_SET_ON_READ]     = hw.sor_release;
    assign hw_vec[A_WRITE_ONLY]      = ALL_ZEROS;
    assign hw_vec[A_WRITE_ONE_SET]   = ALL_ZEROS;
    assign hw_vec[A_WRITE_ONE_CLEAR] = hw.ev_w1c;
    assign hw_vec[A_WRITE_ANY_CLEAR] = hw.ev_wc;
    assign hw_vec[A_LATCH_LOW]       = hw.cond_latch_low;
    assign hw_vec[A_LATCH_HIGH]      = hw.ev_latch_high;
    assign hw_vec[A_SELF_CLEARING]   = ALL_ZEROS;
    assign hw_vec[A_STICKY_HIGH]     = hw.cond_sticky;
    assign hw_vec[A_READ_WRITE]      = ALL_ZEROS;
    assign hw_vec[A_KEPT]            = ALL_ZEROS;

    // ------------------------------------------------------------
    // read pipeline state
    // ------------------------------------------------------------
    rsp_s              rsp_reg;
    rsp_s              rsp_next;
    logic              rd_pend_reg;
    logic [ADDR_W-1:0] rd_addr_reg;

    // ------------------------------------------------------------
    // field storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] q        [NUM_REGS];
    logic [DATA_W-1:0] q_next   [NUM_REGS];
    logic [DATA_W-1:0] rd_term  [NUM_REGS];
    logic [NUM_REGS-1:0] wr_hit;
    logic [NUM_REGS-1:0] fx_hit;
    logic [DATA_W-1:0] seen_q;
    logic [DATA_W-1:0] seen_next;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_field
            // reserved offsets match no field, so their writes fall away
            assign wr_hit[gi]  = acc.wr && sel(acc.addr, gi);
            assign fx_hit[gi]  = rd_pend_reg && sel(rd_addr_reg, gi);
            assign rd_term[gi] = sel(acc.addr, gi) ? read_view(KIND_MAP[gi], q[gi])
                                                   : ALL_ZEROS;
            assign q_next[gi]  = field_next(KIND_MAP[gi], q[gi], hw_vec[gi],
                                            wr_hit[gi], acc.wdata, fx_hit[gi],
                                            rsp_reg.rdata, seen_q);

            field_store #(
                .RST_VAL ((KIND_MAP[gi] == KIND_LATCH_LOW) ? RST_LATCH_LO : RST_ZERO),
                .KEEP    (KIND_MAP[gi] == KIND_KEPT_SOFT_RESET)
            ) u_store (
                .clk      (clk),
                .arst_n   (arst_n),
                .soft_rst (soft_rst),
                .d_next   (q_next[gi]),
                .q        (q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // sticky status read tracking
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] sticky_seen_now;

    assign sticky_seen_now = fx_hit[A_STICKY_HIGH] ? rsp_reg.rdata : ALL_ZEROS;
    // a bit counts as read only while it is still high
    assign seen_next = (seen_q | sticky_seen_now) & q_next[A_STICKY_HIGH];

    field_store #(
        .RST_VAL (RST_ZERO),
        .KEEP    (1'b0)
    ) u_seen (
        .clk      (clk),
        .arst_n   (arst_n),
        .soft_rst (soft_rst),
        .d_next   (seen_next),
        .q        (seen_q)
    );

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_data;

    always_comb begin
        rd_data = ALL_ZEROS; // unmapped and reserved offsets read zero
        for (int i = 0; i < NUM_REGS; i++) begin
            rd_data = rd_data | rd_term[i];
        end
    end

    assign rsp_next.rvalid = acc.rd;
    assign rsp_next.rdata  = acc.rd ? rd_data : ALL_ZEROS;

    // ------------------------------------------------------------
    // read response and side-effect timing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_reg     <= '0;
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= '0;
        end else begin
            rsp_reg     <= rsp_next;
            rd_pend_reg <= acc.rd; // side effects one cycle after the data
            rd_addr_reg <= acc.addr;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rsp                = rsp_reg;
    assign ctrl.wo            = q[A_WRITE_ONLY];
    assign ctrl.w1s           = q[A_WRITE_ONE_SET];
    assign ctrl.self_clearing = q[A_SELF_CLEARING];
    assign ctrl.rw            = q[A_READ_WRITE];
    assign ctrl.kept          = q[A_KEPT];
    assign ctrl.sor           = q[A_SET_ON_READ];

endmodule : reg_field_bank

// ---- shared/field_pkg.sv ----
// field_pkg: shared constants, kinds and carriers of the register field bank
package field_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 4;
    localparam int NUM_REGS = 12;

    // ------------------------------------------------------------
    // field kinds
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        KIND_READ_ONLY        = 4'h0,
        KIND_SET_ON_READ      = 4'h1,
        KIND_WRITE_ONLY       = 4'h2,
        KIND_WRITE_ONE_SET    = 4'h3,
        KIND_WRITE_ONE_CLEAR  = 4'h4,
        KIND_WRITE_ANY_CLEAR  = 4'h5,
        KIND_LATCH_LOW        = 4'h6,
        KIND_LATCH_HIGH       = 4'h7,
        KIND_SELF_CLEARING    = 4'h8,
        KIND_STICKY_HIGH      = 4'h9,
        KIND_READ_WRITE       = 4'hA,
        KIND_KEPT_SOFT_RESET  = 4'hB
    } field_kind_e;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] A_READ_ONLY       = 4'h0;
    localparam logic [3:0] A_SET_ON_READ     = 4'h1;
    localparam logic [3:0] A_WRITE_ONLY      = 4'h2;
    localparam logic [3:0] A_WRITE_ONE_SET   = 4'h3;
    localparam logic [3:0] A_WRITE_ONE_CLEAR = 4'h4;
    localparam logic [3:0] A_WRITE_ANY_CLEAR = 4'h5;
    localparam logic [3:0] A_LATCH_LOW       = 4'h6;
    localparam logic [3:0] A_LATCH_HIGH      = 4'h7;
    localparam logic [3:0] A_SELF_CLEARING   = 4'h8;
    localparam logic [3:0] A_STICKY_HIGH     = 4'h9;
    localparam logic [3:0] A_READ_WRITE      = 4'hA;
    localparam logic [3:0] A_KEPT            = 4'hB;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_LATCH_LO = 8'hFF;
    localparam logic [7:0] ALL_ONES     = 8'hFF;
    localparam logic [7:0] ALL_ZEROS    = 8'h00;

    localparam field_kind_e KIND_MAP [NUM_REGS] = '{
        KIND_READ_ONLY, KIND_SET_ON_READ, KIND_WRITE_ONLY, KIND_WRITE_ONE_SET,
        KIND_WRITE_ONE_CLEAR, KIND_WRITE_ANY_CLEAR, KIND_LATCH_LOW, KIND_LATCH_HIGH,
        KIND_SELF_CLEARING, KIND_STICKY_HIGH, KIND_READ_WRITE, KIND_KEPT_SOFT_RESET
    };

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } acc_s;

    typedef struct packed {
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
    } rsp_s;

    typedef struct packed {
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] sor_release;
        logic [DATA_W-1:0] ev_w1c;
        logic [DATA_W-1:0] ev_wc;
        logic [DATA_W-1:0] cond_latch_low;
        logic [DATA_W-1:0] ev_latch_high;
        logic [DATA_W-1:0] cond_sticky;
    } hw_s;

    typedef struct packed {
        logic [DATA_W-1:0] wo;
        logic [DATA_W-1:0] w1s;
        logic [DATA_W-1:0] self_clearing;
        logic [DATA_W-1:0] rw;
        logic [DATA_W-1:0] kept;
        logic [DATA_W-1:0] sor;
    } ctrl_s;

endpackage : field_pkg

// ---- design/field_store.sv ----
// field_store: one field register with hardware and soft reset handling
`timescale 1ns/1ps
module field_store #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter bit         KEEP    = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       soft_rst,
    input  wire logic [7:0] d_next,
    output logic      [7:0] q
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] q_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_reg <= RST_VAL;
        end else if (soft_rst && !KEEP) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= d_next; // kept fields ignore soft_rst
        end
    end

    assign q = q_reg;

endmodule : field_store

// ---- tb/field_bank_sva.sv ----
// field_bank_sva: port assertions of the register field bank
`timescale 1ns/1ps
module field_bank_sva (
    input wire logic             clk,
    input wire logic             arst_n,
    input wire logic             soft_rst,
    input wire field_pkg::acc_s  acc,
    input wire field_pkg::hw_s   hw,
    input wire field_pkg::rsp_s  rsp,
    input wire field_pkg::ctrl_s ctrl
);
    import field_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic rd_ro       = acc.rd && acc.addr == A_READ_ONLY;
    wire logic rd_sor      = acc.rd && acc.addr == A_SET_ON_READ;
    wire logic rd_zero     = acc.rd && (acc.addr == A_WRITE_ONLY || acc.addr >= 4'hC);
    wire logic wr_w1s      = acc.wr && acc.addr == A_WRITE_ONE_SET;
    wire logic wr_self_clr = acc.wr && acc.addr == A_SELF_CLEARING;
    wire logic wr_rw       = acc.wr && acc.addr == A_READ_WRITE;
    wire logic wr_kept     = acc.wr && acc.addr == A_KEPT;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_rd_answer; acc.rd |=> rsp.rvalid; endproperty
    property p_no_answer; !acc.rd |=> !rsp.rvalid; endproperty
    property p_ro; rd_ro && !$past(soft_rst) |=> rsp.rdata == $past(hw.status, 2); endproperty
    property p_zero; rd_zero |=> rsp.rdata == 8'h00; endproperty
    property p_w1s; wr_w1s && !soft_rst |=> ctrl.w1s == ($past(ctrl.w1s) | $past(acc.wdata));
    endproperty
    property p_sor; rd_sor ##1 !soft_rst |=> ctrl.sor == 8'hFF; endproperty
    property p_self_clr; wr_self_clr && !soft_rst |=> ctrl.self_clearing == $past(acc.wdata);
    endproperty
    property p_self_clr_idle; !wr_self_clr |=> ctrl.self_clearing == 8'h00; endproperty
    property p_rw; wr_rw && !soft_rst |=> ctrl.rw == $past(acc.wdata); endproperty
    property p_kept; soft_rst && !wr_kept |=> $stable(ctrl.kept); endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    a_no_answer: assert property (p_no_answer)
        else $error("answer without read");
    a_ro: assert property (p_ro)
        else $error("read-only value wrong");
    a_zero: assert property (p_zero)
        else $error("write-only or reserved read not zero");
    a_w1s: assert property (p_w1s)
        else $error("write-one-to-set wrong");
    a_sor: assert property (p_sor)
        else $error("set-on-read not set");
    a_self_clr: assert property (p_self_clr)
        else $error("self-clearing not set");
    a_self_clr_idle: assert property (p_self_clr_idle)
        else $error("self-clearing not cleared");
    a_rw: assert property (p_rw)
        else $error("read-write not stored");
    a_kept: assert property (p_kept)
        else $error("kept field changed by soft reset");
    c_sor: cover property (rd_sor);
    c_self_clr: cover property (wr_self_clr);
    c_soft: cover property (soft_rst);
endmodule : field_bank_sva

// ---- tb/testbench.sv ----
// testbench: directed scenarios for the register field bank
`timescale 1ns/1ps
module testbench;
    import field_pkg::*;
    logic       clk      = 1'b0;
    logic       arst_n   = 1'b0;
    logic       soft_rst = 1'b0;
    acc_s       acc      = '0;
    hw_s        hw       = '{cond_latch_low: 8'hFF, default: 8'h00};
    rsp_s       rsp;
    ctrl_s      ctrl;
    int         miscompares = 0;
    int         checked     = 0;
    logic [7:0] rdv;
    always #5 clk = ~clk;
    reg_field_bank i_dut (.clk(clk), .arst_n(arst_n), .soft_rst(soft_rst), .acc(acc),
        .hw(hw), .rsp(rsp), .ctrl(ctrl));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        tick();
        acc = '{1'b0, 1'b1, a, d};
        tick();
        acc.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        tick();
        acc = '{1'b1, 1'b0, a, 8'h00};
        tick();
        acc.rd = 1'b0;
        chk({7'h00, rsp.rvalid}, 8'h01);
        d = rsp.rdata;
    endtask : rd
    task automatic test_done;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_sor;
        rd(A_SET_ON_READ, rdv);
        chk(rdv, 8'h00);
        tick();
        chk(ctrl.sor, 8'hFF);
        hw.sor_release = 8'h0F;
        tick();
        hw.sor_release = 8'h00;
        rd(A_SET_ON_READ, rdv);
        chk(rdv, 8'hF0);
    endtask : s_sor
    task automatic s_write;
        hw.status = 8'h5A;
        wr(A_READ_ONLY, 8'hFF);
        rd(A_READ_ONLY, rdv);
        chk(rdv, 8'h5A);
        wr(A_WRITE_ONLY, 8'h3C);
        chk(ctrl.wo, 8'h3C);
        rd(A_WRITE_ONLY, rdv);
        wr(A_WRITE_ONE_SET, 8'h05);
        wr(A_WRITE_ONE_SET, 8'h0A);
        wr(A_WRITE_ONE_SET, 8'h00);
        chk(ctrl.w1s, 8'h0F);
    endtask : s_write
    task automatic s_clear;
        hw.ev_w1c = 8'hFF;
        hw.ev_wc = 8'hFF;
        tick();
        hw.ev_w1c = 8'h00;
        hw.ev_wc = 8'h00;
        wr(A_WRITE_ONE_CLEAR, 8'h0F);
        rd(A_WRITE_ONE_CLEAR, rdv);
        chk(rdv, 8'hF0);
        wr(A_WRITE_ANY_CLEAR, 8'h00);
        rd(A_WRITE_ANY_CLEAR, rdv);
        chk(rdv, 8'h00);
    endtask : s_clear
    task automatic s_latch;
        hw.cond_latch_low = 8'hF0;
        hw.ev_latch_high = 8'h81;
        tick();
        hw.cond_latch_low = 8'hFF;
        hw.ev_latch_high = 8'h00;
        rd(A_LATCH_LOW, rdv);
        chk(rdv, 8'hF0);
        rd(A_LATCH_LOW, rdv);
        chk(rdv, 8'hFF);
        tick();
        acc = '{1'b1, 1'b0, A_LATCH_HIGH, 8'h00};
        tick();
        chk(rsp.rdata, 8'h81);
        tick();
        acc.rd = 1'b0;
        chk(rsp.rdata, 8'h81);
        rd(A_LATCH_HIGH, rdv);
        chk(rdv, 8'h00);
    endtask : s_latch
    task automatic s_self_clr;
        wr(A_SELF_CLEARING, 8'h11);
        chk(ctrl.self_clearing, 8'h11);
        tick();
        chk(ctrl.self_clearing, 8'h00);
        wr(A_SELF_CLEARING, 8'h00);
        chk(ctrl.self_clearing, 8'h00);
    endtask : s_self_clr
    task automatic s_sticky;
        hw.cond_sticky = 8'h01;
        tick();
        tick();
        hw.cond_sticky = 8'h00;
        rd(A_STICKY_HIGH, rdv);
        chk(rdv, 8'h01);
        tick();
        rd(A_STICKY_HIGH, rdv);
        chk(rdv, 8'h00);
        hw.cond_sticky = 8'h01;
        rd(A_STICKY_HIGH, rdv);
        chk(rdv, 8'h01);
        tick();
        rd(A_STICKY_HIGH, rdv);
        chk(rdv, 8'h01);
        hw.cond_sticky = 8'h00;
        tick();
        tick();
        rd(A_STICKY_HIGH, rdv);
        chk(rdv, 8'h00);
    endtask : s_sticky
    task automatic s_soft;
        wr(A_READ_WRITE, 8'h5A);
        rd(A_READ_WRITE, rdv);
        chk(rdv, 8'h5A);
        wr(A_KEPT, 8'hA5);
        soft_rst = 1'b1;
        tick();
        soft_rst = 1'b0;
        chk(ctrl.rw, 8'h00);
        chk(ctrl.kept, 8'hA5);
        wr(4'hC, 8'h00);
        rd(4'hC, rdv);
    endtask : s_soft
    initial begin
        repeat (6) @(posedge clk);
        #1;
        arst_n = 1'b1;
        s_sor();
        s_write();
        s_clear();
        s_latch();
        s_self_clr();
        s_sticky();
        s_soft();
        test_done();
    end
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
endmodule : testbench
bind reg_field_bank field_bank_sva i_sva (.clk(clk), .arst_n(arst_n), .soft_rst(soft_rst),
    .acc(acc), .hw(hw), .rsp(rsp), .ctrl(ctrl));
